// ==== prca_pkg.sv ====
/*
  Shared constants, states and timing counts of the pump run command
  arbiter. Assumes a 100 MHz system clock with a 10 ns period.
*/
package prca_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Start-up self test time in milliseconds.
  localparam int unsigned STARTUP_TIME_MS = 15000;
  localparam int unsigned STARTUP_CYCLES =
    STARTUP_TIME_MS * (1000000 / CLK_PERIOD_NS);
  // Least pulse width on the 25-way start and stop inputs, in ms.
  localparam int unsigned PULSE_MIN_MS = 99;
  localparam int unsigned PULSE_CYCLES = PULSE_MIN_MS * 100000 + 1;
  // Default response delay of the serial link in milliseconds.
  localparam int unsigned RESP_DELAY_DEF_MS = 10;
  localparam int unsigned RESP_DELAY_CYCLES = RESP_DELAY_DEF_MS * 100000;
  // Serial link bit rate and bit period in cycles.
  localparam int unsigned BAUD_RATE = 19200;
  localparam int unsigned BAUD_CYCLES = 100000000 / BAUD_RATE;
  localparam int unsigned CNT_W = 31;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 4'hF;
  // Flash periods of the load indicators in cycles.
  localparam logic [CNT_W-1:0] FLASH_LONG = 31'h04C4B400;
  localparam logic [CNT_W-1:0] FLASH_SHORT = 31'h01312D00;
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [4:0] {
    PRCA_ST_TEST = 5'h01,
    PRCA_ST_ACK_WAIT = 5'h02,
    PRCA_ST_ACK_HOLD = 5'h04,
    PRCA_ST_ACK_REL = 5'h08,
    PRCA_ST_READY = 5'h10
  } prca_state_type;
endpackage : prca_pkg

// ==== prca_sync_if.sv ====
/*
  Carries the synchronised external control levels from the input
  synchroniser to the arbiter. Assumes one system clock.
*/
interface prca_sync_if;
  logic key_start;
  logic key_stop;
  logic plc_start;
  logic plc_stop;
  logic remote_en;
  logic r_start;
  logic r_stop_n;
  modport src (output key_start, key_stop, plc_start, plc_stop,
    remote_en, r_start, r_stop_n);
  modport dst (input key_start, key_stop, plc_start, plc_stop,
    remote_en, r_start, r_stop_n);
endinterface : prca_sync_if

// ==== prca_input_sync.sv ====
/*
  Three-stage synchroniser for the external control pins. A level is
  accepted once the second and third stages agree. Assumes pins are
  asynchronous to sys_clk_in.
*/
module prca_input_sync
  import prca_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [6:0] pins_in,
  prca_sync_if.src sync
);
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] lvl;
  } prca_sync_state_type;

  prca_sync_state_type st_q;
  prca_sync_state_type st_d;

  // Shift the pins through three stages and update when stages agree.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 7; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  // Registers the synchroniser state.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync.key_start = st_q.lvl[0];
  assign sync.key_stop = st_q.lvl[1];
  assign sync.plc_start = st_q.lvl[2];
  assign sync.plc_stop = st_q.lvl[3];
  assign sync.remote_en = st_q.lvl[4];
  assign sync.r_start = st_q.lvl[5];
  assign sync.r_stop_n = st_q.lvl[6];
endmodule : prca_input_sync

// ==== prca_pulse_qual.sv ====
/*
  Pulse width qualifier: raises a one-cycle pulse when its input has
  stood at the active level for the given number of cycles. Assumes a
  synchronised input.
*/
module prca_pulse_qual
  import prca_pkg::*;
#(
  parameter logic [CNT_W-1:0] MIN_CYCLES = CNT_W'(PULSE_CYCLES)
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic active_in,
  output logic pulse_out
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic fired;
  } prca_pq_state_type;

  prca_pq_state_type st_q;
  prca_pq_state_type st_d;

  // Count the active time and fire once when it exceeds the minimum.
  always_comb begin
    st_d = st_q;
    if (!active_in) begin
      st_d.cnt = '0;
      st_d.fired = 1'b0;
    end else if (st_q.cnt < MIN_CYCLES) begin
      st_d.cnt = st_q.cnt + CNT_W'(1);
    end else begin
      st_d.fired = 1'b1;
    end
  end

  // Registers the counter state.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse_out = active_in && (st_q.cnt >= MIN_CYCLES) && !st_q.fired;
endmodule : prca_pulse_qual

// ==== prca_arbiter.sv ====
/*
  Run/stop command arbiter of a pump frequency converter: start-up
  self test with pump check and key chord, key and 9-way port merge,
  25-way port gating with pulse qualification, serial link settings,
  the bit rate tick and the reply delay timing.
  Assumes the key, port and rotary switch pins are asynchronous to
  sys_clk_in and pass the synchronisers here before use; that the
  nonvolatile load and the pump detection report through plain levels
  on this clock; that the option board selection and its commands and
  the serial frame strobe come from logic on this clock; and that a
  reset stands for a power cycle, the only moment at which the bus
  address is taken again.
  Frames that arrive while a reply is pending are dropped.
*/
module prca_arbiter
  import prca_pkg::*;
#(
  parameter logic [CNT_W-1:0] STARTUP_CNT = CNT_W'(STARTUP_CYCLES),
  parameter logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYCLES)
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic key_start_in,
  input wire logic key_stop_in,
  input wire logic plc_port_9way_start_in,
  input wire logic plc_port_9way_stop_in,
  input wire logic remote_en_in,
  input wire logic remote_start_in,
  input wire logic remote_stop_n_in,
  input wire logic option_ctrl_in,
  input wire logic option_start_in,
  input wire logic option_stop_in,
  input wire logic params_loaded_in,
  input wire logic pump_detected_in,
  input wire logic pump_match_in,
  input wire logic [ADDR_W-1:0] rotary_addr_in,
  input wire logic [ADDR_W-1:0] frame_addr_in,
  input wire logic frame_done_in,
  input wire logic [15:0] resp_delay_ms_in,
  output logic pump_run_out,
  output logic ready_out,
  output logic fault_led_out,
  output logic load_led_a_out,
  output logic load_led_b_out,
  output logic [ADDR_W-1:0] bus_addr_out,
  output logic reply_go_out,
  output logic baud_tick_out
);
  // Synchronised pin levels travel in one bundle.
  prca_sync_if sync ();

  // Qualified one-cycle pulses of the 25-way start and stop inputs.
  logic r_start_pulse;
  logic r_stop_pulse;

  // Bring the key and port pins into the clock domain.
  prca_input_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pins_in({remote_stop_n_in, remote_start_in, remote_en_in,
      plc_port_9way_stop_in, plc_port_9way_start_in, key_stop_in,
      key_start_in}),
    .sync(sync)
  );

  // Qualify the 25-way start (high) and stop (low) pulses.
  prca_pulse_qual #(.MIN_CYCLES(PULSE_CNT)) u_rstart (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .active_in(sync.r_start && sync.remote_en),
    .pulse_out(r_start_pulse)
  );

  prca_pulse_qual #(.MIN_CYCLES(PULSE_CNT)) u_rstop (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .active_in(!sync.r_stop_n && sync.remote_en),
    .pulse_out(r_stop_pulse)
  );

  // All control state in one record, registered by one process.
  typedef struct packed {
    prca_state_type state;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] flash;
    logic flash_long;
    logic flash_ph;
    logic no_pump;
    logic mismatch;
    logic init_done;
    logic run;
    logic [3:0] prev;
    logic [ADDR_W-1:0] addr;
    logic addr_valid;
    logic [ADDR_W-1:0] rot_s1;
    logic [ADDR_W-1:0] rot_s2;
    logic [ADDR_W-1:0] rot_s3;
    logic [CNT_W-1:0] resp_cnt;
    logic resp_busy;
    logic [15:0] baud_cnt;
    logic rdy;
    logic lamp_a;
    logic lamp_b;
    logic tick;
  } prca_state_all_type;

  prca_state_all_type st_q;
  prca_state_all_type st_d;

  // Source enables, line edges, merged commands and the reply target.
  logic key_en;
  logic plc_en;
  logic plc_start_edge;
  logic plc_stop_edge;
  logic key_start_edge;
  logic key_stop_edge;
  logic [CNT_W-1:0] resp_target;
  logic [47:0] resp_prod;
  logic cmd_stop;
  logic cmd_start;
  logic frame_hit;

  // Cycles in one millisecond, taken from the default reply delay.
  localparam logic [CNT_W-1:0] MS_CYCLES =
    CNT_W'(RESP_DELAY_CYCLES / RESP_DELAY_DEF_MS);

  // Sources enabled only when no option board holds control.
  assign key_en = !option_ctrl_in;
  assign plc_en = !option_ctrl_in;
  // Edges on the synchronised lines drive commands.
  assign plc_start_edge = sync.plc_start && !st_q.prev[0];
  assign plc_stop_edge = sync.plc_stop && !st_q.prev[1];
  assign key_start_edge = sync.key_start && !st_q.prev[2];
  assign key_stop_edge = sync.key_stop && !st_q.prev[3];

  // Stop and start requests of the enabled sources; stop wins.
  assign cmd_stop = (key_en && key_stop_edge) ||
    (plc_en && plc_stop_edge) || r_stop_pulse;
  assign cmd_start = (key_en && key_start_edge) ||
    (plc_en && plc_start_edge) || r_start_pulse;

  // A frame counts only for the latched address and once ready.
  assign frame_hit = frame_done_in && frame_addr_in == st_q.addr &&
    st_q.state == PRCA_ST_READY;

  // The full delay range overflows the counter: clamp to its maximum.
  assign resp_prod = 48'(resp_delay_ms_in) * 48'(MS_CYCLES);
  assign resp_target = (|resp_prod[47:CNT_W]) ? '1 :
    resp_prod[CNT_W-1:0];

  // Start-up sequence, command merge, address latch and reply timing.
  always_comb begin
    st_d = st_q;
    // Remember the line levels for edges; the bit rate counter wraps.
    st_d.prev = {sync.key_stop, sync.key_start, sync.plc_stop,
      sync.plc_start};
    st_d.baud_cnt = (st_q.baud_cnt == 16'(BAUD_CYCLES - 1)) ?
      16'h0000 : st_q.baud_cnt + 16'h0001;

    // Pass the rotary switch through three stages before it is used.
    st_d.rot_s1 = rotary_addr_in;
    st_d.rot_s2 = st_q.rot_s1;
    st_d.rot_s3 = st_q.rot_s2;

    case (st_q.state)
      PRCA_ST_TEST: begin
        // Self test: count the start-up time, wait for the parameters.
        st_d.tmr = st_q.tmr + CNT_W'(1);
        // Latch the address once, when the last two stages agree.
        if (!st_q.addr_valid && st_q.tmr >= CNT_W'(SYNC_STAGES) &&
            st_q.rot_s2 == st_q.rot_s3) begin
          st_d.addr = st_q.rot_s3;
          st_d.addr_valid = 1'b1;
        end
        if (st_q.tmr >= STARTUP_CNT - CNT_W'(1) && params_loaded_in) begin
          st_d.no_pump = !pump_detected_in;
          st_d.mismatch = pump_detected_in && !pump_match_in;
          st_d.tmr = '0;
          if (!pump_detected_in || !pump_match_in) begin
            st_d.state = PRCA_ST_ACK_WAIT;
          end else begin
            st_d.state = PRCA_ST_READY;
          end
        end
      end

      PRCA_ST_ACK_WAIT: begin
        // The chord stays usable even with an option board in control.
        if (sync.key_stop && !sync.key_start) begin
          st_d.state = PRCA_ST_ACK_HOLD;
        end
      end

      PRCA_ST_ACK_HOLD: begin
        // Stop held: a start press moves on, a stop release starts over.
        if (!sync.key_stop) begin
          st_d.state = PRCA_ST_ACK_WAIT;
        end else if (sync.key_start) begin
          st_d.state = PRCA_ST_ACK_REL;
        end
      end

      PRCA_ST_ACK_REL: begin
        // Start released with stop still held accepts the pump.
        if (!sync.key_stop) begin
          st_d.state = PRCA_ST_ACK_WAIT;
        end else if (!sync.key_start) begin
          st_d.state = PRCA_ST_READY;
          st_d.no_pump = 1'b0;
          st_d.mismatch = 1'b0;
          st_d.prev[3] = 1'b1;
        end
      end

      PRCA_ST_READY: begin
        // The first ready cycle takes the port levels as the command.
        if (!st_q.init_done) begin
          st_d.init_done = 1'b1;
          st_d.run = plc_en && sync.plc_start && !sync.plc_stop;
        end else if (option_ctrl_in) begin
          if (option_stop_in) begin
            st_d.run = 1'b0;
          end else if (option_start_in) begin
            st_d.run = 1'b1;
          end
        end else begin
          // Stop wins when both sources strike in one cycle.
          if (cmd_stop) begin
            st_d.run = 1'b0;
          end else if (cmd_start) begin
            st_d.run = 1'b1;
          end
        end
      end

      // An illegal state code returns to the self test.
      default: begin
        st_d.state = PRCA_ST_TEST;
      end
    endcase

    // Alternate the load lamps with long and short phases.
    if (st_q.mismatch) begin
      st_d.flash = st_q.flash + CNT_W'(1);
      if (st_q.flash >= (st_q.flash_long ? FLASH_LONG : FLASH_SHORT)) begin
        st_d.flash = '0;
        st_d.flash_ph = !st_q.flash_ph;
        st_d.flash_long = !st_q.flash_long;
      end
    end

    // Reply waits the response delay after a frame for this address.
    if (st_q.resp_busy) begin
      if (st_q.resp_cnt >= resp_target) begin
        st_d.resp_busy = 1'b0;
      end else begin
        st_d.resp_cnt = st_q.resp_cnt + CNT_W'(1);
      end
    end else if (frame_hit) begin
      st_d.resp_busy = 1'b1;
      st_d.resp_cnt = '0;
    end

    // Output flops follow the next state, so they need no extra cycle.
    st_d.rdy = st_d.state == PRCA_ST_READY;
    st_d.lamp_a = st_d.mismatch && st_d.flash_ph;
    st_d.lamp_b = st_d.mismatch && !st_d.flash_ph;
    st_d.tick = st_d.baud_cnt == 16'h0000;
  end

  // Registers all control state.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_q <= '{state: PRCA_ST_TEST, flash_long: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Data outputs come straight from the state flops; reply_go_out also compares resp_cnt with resp_target.
  assign pump_run_out = st_q.run;
  assign ready_out = st_q.rdy;
  assign fault_led_out = st_q.no_pump;
  assign load_led_a_out = st_q.lamp_a;
  assign load_led_b_out = st_q.lamp_b;
  assign bus_addr_out = st_q.addr;
  assign reply_go_out = st_q.resp_busy && st_q.resp_cnt >= resp_target;
  assign baud_tick_out = st_q.tick;
endmodule : prca_arbiter

// ==== prca_arbiter_asserts.sv ====
/*
  Concurrent checks on the pump run command arbiter ports.
  Assumes one clock domain and the synchronous reset_in.
*/
module prca_arbiter_asserts
  import prca_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic option_ctrl_in,
  input wire logic option_start_in,
  input wire logic option_stop_in,
  input wire logic remote_en_in,
  input wire logic pump_detected_in,
  input wire logic pump_run_out,
  input wire logic ready_out,
  input wire logic fault_led_out,
  input wire logic [ADDR_W-1:0] bus_addr_out,
  input wire logic reply_go_out,
  input wire logic baud_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  logic [12:0] gap_q;
  logic seen_q;
  // Counts the cycles since the last bit rate tick.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (baud_tick_out) begin
      gap_q <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 13'h0001;
    end
  end
  property p_opt_lock;
    (ready_out && option_ctrl_in && !option_start_in && !option_stop_in
      && !remote_en_in) [*6] |-> $stable(pump_run_out);
  endproperty
  a_opt_lock: assert property (p_opt_lock)
    else $error("Run changed while option board held control.");
  property p_no_run_early;
    !ready_out |-> !pump_run_out;
  endproperty
  a_no_run_early: assert property (p_no_run_early)
    else $error("Run active before ready.");
  property p_ready_late;
    $fell(reset_in) |-> !ready_out [*8];
  endproperty
  a_ready_late: assert property (p_ready_late)
    else $error("Ready came too soon after reset.");
  property p_fault_cause;
    $rose(fault_led_out) |-> !$past(pump_detected_in);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("Fault lamp lit with pump detected.");
  property p_addr_hold;
    ready_out && $past(ready_out) |-> $stable(bus_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("Bus address changed without power cycle.");
  property p_baud;
    baud_tick_out && seen_q |-> gap_q == 13'(BAUD_CYCLES - 1);
  endproperty
  a_baud: assert property (p_baud)
    else $error("Bit rate tick spacing wrong.");
  property p_reply_ready;
    reply_go_out |-> ready_out;
  endproperty
  a_reply_ready: assert property (p_reply_ready)
    else $error("Reply released while not ready.");
  property p_reply_pulse;
    reply_go_out |=> !reply_go_out;
  endproperty
  a_reply_pulse: assert property (p_reply_pulse)
    else $error("Reply release longer than one cycle.");
endmodule : prca_arbiter_asserts

// ==== prca_plc_model.sv ====
/*
  Behavioural controller driving the 9-way and 25-way port lines.
  Assumes the bench calls its tasks; lines change at falling edges.
*/
module prca_plc_model (
  input wire logic sys_clk_in,
  output logic plc_start_out,
  output logic plc_stop_out,
  output logic remote_en_out,
  output logic remote_start_out,
  output logic remote_stop_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power-on levels: start line already asserted.
  initial begin
    plc_start_out = 1'b1;
    plc_stop_out = 1'b0;
    remote_en_out = 1'b0;
    remote_start_out = 1'b0;
    remote_stop_n_out = 1'b1;
  end
  // Sets both 9-way levels; commands are the edges between calls.
  task automatic set9(input logic st, input logic sp);
    @(negedge sys_clk_in);
    plc_start_out = st;
    plc_stop_out = sp;
    repeat (8) @(negedge sys_clk_in);
  endtask : set9
  task automatic set_en(input logic en);
    @(negedge sys_clk_in);
    remote_en_out = en;
  endtask : set_en
  // Drives one 25-way start or stop pulse of len cycles.
  task automatic pulse25(input logic stop, input int len);
    @(negedge sys_clk_in);
    if (stop) remote_stop_n_out = 1'b0;
    else remote_start_out = 1'b1;
    repeat (len) @(negedge sys_clk_in);
    remote_stop_n_out = 1'b1;
    remote_start_out = 1'b0;
    repeat (8) @(negedge sys_clk_in);
  endtask : pulse25
endmodule : prca_plc_model

// ==== tb_top.sv ====
/*
  Self-checking bench of the run command arbiter with a controller
  model. Assumes short start-up and pulse counts set below.
*/
module tb_top
  import prca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0, reset_in = 1'b1;
  logic key_start_in = 1'b0, key_stop_in = 1'b0, option_ctrl_in = 1'b0;
  logic option_start_in = 1'b0, option_stop_in = 1'b0, frame_done_in = 1'b0;
  logic pump_detected_in = 1'b1, pump_match_in = 1'b1;
  logic params_loaded_in = 1'b1;
  logic [ADDR_W-1:0] rotary_addr_in = 4'h5, frame_addr_in = 4'h0;
  logic [15:0] resp_delay_ms_in = 16'h0000;
  logic ps, pp, re, rs, rn, run, rdy, flt, la, lb, rg, bt;
  logic [ADDR_W-1:0] ba;
  int error_cnt = 0, n_checks = 0;
  prca_arbiter #(.STARTUP_CNT(31'h64), .PULSE_CNT(31'h14)) prca_arbiter_inst (
    .sys_clk_in, .reset_in, .key_start_in, .key_stop_in,
    .plc_port_9way_start_in(ps), .plc_port_9way_stop_in(pp),
    .remote_en_in(re), .remote_start_in(rs), .remote_stop_n_in(rn),
    .option_ctrl_in, .option_start_in, .option_stop_in, .params_loaded_in,
    .pump_detected_in, .pump_match_in, .rotary_addr_in, .frame_addr_in,
    .frame_done_in, .resp_delay_ms_in, .pump_run_out(run), .ready_out(rdy),
    .fault_led_out(flt), .load_led_a_out(la), .load_led_b_out(lb),
    .bus_addr_out(ba), .reply_go_out(rg), .baud_tick_out(bt));
  prca_plc_model prca_plc_model_inst (.sys_clk_in, .plc_start_out(ps),
    .plc_stop_out(pp), .remote_en_out(re), .remote_start_out(rs),
    .remote_stop_n_out(rn));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic key(input logic st, input logic sp);
    @(negedge sys_clk_in);
    key_start_in = st;
    key_stop_in = sp;
    repeat (8) @(negedge sys_clk_in);
  endtask : key
  task automatic opt(input logic st, input logic sp);
    @(negedge sys_clk_in);
    option_start_in = st;
    option_stop_in = sp;
    @(negedge sys_clk_in);
    option_start_in = 1'b0;
    option_stop_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
  endtask : opt
  // Sends one frame and looks for the reply release within 20 cycles.
  task automatic reply(input logic [3:0] a, input logic e);
    logic got;
    got = 1'b0;
    @(negedge sys_clk_in);
    frame_addr_in = a;
    frame_done_in = 1'b1;
    @(negedge sys_clk_in);
    frame_done_in = 1'b0;
    repeat (20) begin
      got = got | rg;
      @(negedge sys_clk_in);
    end
    chk("reply", {3'h0, e}, {3'h0, got});
  endtask : reply
  task automatic rst();
    @(negedge sys_clk_in);
    reset_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (90) @(negedge sys_clk_in);
    chk("ready_early", 4'h0, b(rdy));
    repeat (60) @(negedge sys_clk_in);
  endtask : rst
  function automatic logic [3:0] b(input logic v);
    return {3'h0, v};
  endfunction : b
  // Main sequence of command scenarios.
  initial begin
    rst();
    chk("ready", 4'h1, b(rdy));
    chk("addr", 4'h5, ba);
    chk("run", 4'h1, b(run));
    key(1'b0, 1'b1);
    key(1'b0, 1'b0);
    repeat (30) @(negedge sys_clk_in);
    chk("run", 4'h0, b(run));
    prca_plc_model_inst.set9(1'b0, 1'b1);
    prca_plc_model_inst.set9(1'b0, 1'b0);
    prca_plc_model_inst.set9(1'b1, 1'b0);
    chk("run", 4'h1, b(run));
    prca_plc_model_inst.set9(1'b0, 1'b1);
    chk("run", 4'h0, b(run));
    key(1'b1, 1'b0);
    key(1'b0, 1'b0);
    chk("run", 4'h1, b(run));
    prca_plc_model_inst.set9(1'b1, 1'b1);
    prca_plc_model_inst.set9(1'b0, 1'b0);
    prca_plc_model_inst.set9(1'b0, 1'b1);
    chk("run", 4'h0, b(run));
    option_ctrl_in = 1'b1;
    key(1'b1, 1'b0);
    key(1'b0, 1'b0);
    prca_plc_model_inst.set9(1'b1, 1'b0);
    chk("run", 4'h0, b(run));
    opt(1'b1, 1'b0);
    key(1'b0, 1'b1);
    key(1'b0, 1'b0);
    chk("run", 4'h1, b(run));
    opt(1'b0, 1'b1);
    chk("run", 4'h0, b(run));
    option_ctrl_in = 1'b0;
    prca_plc_model_inst.pulse25(1'b0, 40);
    chk("run", 4'h0, b(run));
    prca_plc_model_inst.set_en(1'b1);
    prca_plc_model_inst.pulse25(1'b0, 20);
    chk("run", 4'h0, b(run));
    prca_plc_model_inst.pulse25(1'b0, 21);
    chk("run", 4'h1, b(run));
    prca_plc_model_inst.pulse25(1'b1, 20);
    chk("run", 4'h1, b(run));
    prca_plc_model_inst.pulse25(1'b1, 21);
    chk("run", 4'h0, b(run));
    prca_plc_model_inst.set_en(1'b0);
    rotary_addr_in = 4'h9;
    repeat (10) @(negedge sys_clk_in);
    chk("addr", 4'h5, ba);
    reply(4'h5, 1'b1);
    reply(4'h3, 1'b0);
    pump_detected_in = 1'b0;
    prca_plc_model_inst.set9(1'b0, 1'b0);
    rst();
    chk("fault", 4'h1, b(flt));
    chk("ready", 4'h0, b(rdy));
    chk("addr", 4'h9, ba);
    key(1'b0, 1'b1);
    key(1'b1, 1'b1);
    key(1'b0, 1'b1);
    key(1'b0, 1'b0);
    chk("ready", 4'h1, b(rdy));
    chk("fault", 4'h0, b(flt));
    // Mismatched pump, accepted by the chord under option control.
    pump_detected_in = 1'b1;
    pump_match_in = 1'b0;
    option_ctrl_in = 1'b1;
    rst();
    chk("fault", 4'h0, b(flt));
    chk("load_a", 4'h0, b(la));
    chk("load_b", 4'h1, b(lb));
    key(1'b0, 1'b1);
    key(1'b1, 1'b1);
    key(1'b0, 1'b1);
    key(1'b0, 1'b0);
    chk("ready", 4'h1, b(rdy));
    chk("load_b", 4'h0, b(lb));
    chk("run", 4'h0, b(run));
    option_ctrl_in = 1'b0;
    repeat (11000) @(negedge sys_clk_in);
    conclude();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    error_cnt++;
    conclude();
  end
endmodule : tb_top
bind prca_arbiter prca_arbiter_asserts prca_arbiter_asserts_inst (
  .sys_clk_in, .reset_in, .option_ctrl_in, .option_start_in,
  .option_stop_in, .remote_en_in, .pump_detected_in, .pump_run_out,
  .ready_out, .fault_led_out, .bus_addr_out, .reply_go_out, .baud_tick_out);
